// ### rtl/led_slot_control_regs.sv
// Emitter slot assignment and third driver control registers.
// Assumes the host register port is already on clock_i (the serial front end sits upstream).
`timescale 1ns/1ps
`include "led_slot_defs.svh"

module led_slot_control_regs (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   resetn_i,
  // Host register port
  input  wire led_slot_pkg::reg_addr_t reg_addr_i,
  input  wire logic                   reg_write_i,
  input  wire led_slot_pkg::reg_word_t reg_wdata_i,
  input  wire logic                   reg_read_i,
  output led_slot_pkg::reg_word_t     reg_rdata_o,
  output logic                        reg_rvalid_o,
  // Slot configuration towards the timing and switch logic
  output logic [3:0]                  slot_a_diode_select_o,
  output logic [3:0]                  slot_b_diode_select_o,
  output logic [2:0]                  slot_a_emitter_enable_o,
  output logic [2:0]                  slot_b_emitter_enable_o,
  output logic                        slot_a_float_mode_o,
  output logic                        slot_b_float_mode_o,
  // Third emitter driver settings
  output logic                        third_driver_strength_o,
  output logic [2:0]                  third_driver_edge_rate_o,
  output logic [3:0]                  third_driver_coarse_current_o
);

  led_slot_pkg::reg_word_t slot_emitter_select;
  led_slot_pkg::reg_word_t third_driver_control;

  // Address decode
  wire logic hit_slot;
  wire logic hit_third;
  wire logic write_slot;
  wire logic write_third;
  assign hit_slot    = (reg_addr_i == `SLOT_EMITTER_SELECT_ADDR);
  assign hit_third   = (reg_addr_i == `THIRD_DRIVER_CONTROL_ADDR);
  assign write_slot  = reg_write_i & hit_slot;
  assign write_third = reg_write_i & hit_third;

  // Read selection; unmapped addresses read as zero
  wire led_slot_pkg::reg_word_t next_rdata;
  assign next_rdata = hit_slot  ? slot_emitter_select :
                      hit_third ? third_driver_control : 16'h0000;

  // Whole words are stored, reserved bits included, so reads return what was written
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot_emitter_select <= `SLOT_EMITTER_SELECT_RESET;
    end else if (write_slot) begin
      slot_emitter_select <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      third_driver_control <= `THIRD_DRIVER_CONTROL_RESET;
    end else if (write_third) begin
      third_driver_control <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_read_i;
      if (reg_read_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // Field outputs, registered one cycle behind the register words
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot_a_diode_select_o         <= 4'h4;
      slot_b_diode_select_o         <= 4'h5;
      third_driver_strength_o       <= 1'b1;
      third_driver_edge_rate_o      <= 3'h0;
      third_driver_coarse_current_o <= 4'h0;
    end else begin
      slot_b_diode_select_o <=
        slot_emitter_select[`SLOT_B_DIODE_MSB:`SLOT_B_DIODE_LSB];
      slot_a_diode_select_o <=
        slot_emitter_select[`SLOT_A_DIODE_MSB:`SLOT_A_DIODE_LSB];
      third_driver_strength_o <= third_driver_control[`THIRD_STRENGTH_BIT];
      third_driver_edge_rate_o <=
        third_driver_control[`THIRD_EDGE_RATE_MSB:`THIRD_EDGE_RATE_LSB];
      third_driver_coarse_current_o <=
        third_driver_control[`THIRD_COARSE_MSB:`THIRD_COARSE_LSB];
    end
  end

  // Per-slot emitter decode: index 0 is slot A, index 1 is slot B
  wire led_slot_pkg::emitter_code_e slot_code [2];
  wire logic [2:0]                  slot_enable [2];
  wire logic                        slot_float [2];
  assign slot_code[0] = led_slot_pkg::emitter_code_e'(
    slot_emitter_select[`SLOT_A_EMITTER_MSB:`SLOT_A_EMITTER_LSB]);
  assign slot_code[1] = led_slot_pkg::emitter_code_e'(
    slot_emitter_select[`SLOT_B_EMITTER_MSB:`SLOT_B_EMITTER_LSB]);

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_slot
      slot_emitter_decode u_decode (
        .clock_i          (clock_i),
        .resetn_i         (resetn_i),
        .code_i           (slot_code[s]),
        .emitter_enable_o (slot_enable[s]),
        .float_mode_o     (slot_float[s])
      );
    end
  endgenerate

  // Second register stage keeps the top outputs straight from flip-flops
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot_a_emitter_enable_o <= 3'h0;
      slot_b_emitter_enable_o <= 3'h0;
      slot_a_float_mode_o     <= 1'b0;
      slot_b_float_mode_o     <= 1'b0;
    end else begin
      slot_a_emitter_enable_o <= slot_enable[0];
      slot_b_emitter_enable_o <= slot_enable[1];
      slot_a_float_mode_o     <= slot_float[0];
      slot_b_float_mode_o     <= slot_float[1];
    end
  end

endmodule : led_slot_control_regs

// ### include/led_slot_defs.svh
// Offsets, field positions and reset values of the emitter slot registers.
// Included by the register bank, its checker and its bench by bare name.
`ifndef LED_SLOT_DEFS_SVH
`define LED_SLOT_DEFS_SVH

// Register offsets on the host register port
`define SLOT_EMITTER_SELECT_ADDR   8'h14
`define THIRD_DRIVER_CONTROL_ADDR  8'h22

// Slot selection register fields
`define SLOT_B_DIODE_MSB           11
`define SLOT_B_DIODE_LSB           8
`define SLOT_A_DIODE_MSB           7
`define SLOT_A_DIODE_LSB           4
`define SLOT_B_EMITTER_MSB         3
`define SLOT_B_EMITTER_LSB         2
`define SLOT_A_EMITTER_MSB         1
`define SLOT_A_EMITTER_LSB         0

// Third driver register fields
`define THIRD_STRENGTH_BIT         13
`define THIRD_EDGE_RATE_MSB        6
`define THIRD_EDGE_RATE_LSB        4
`define THIRD_COARSE_MSB           3
`define THIRD_COARSE_LSB           0

// Reset values
`define SLOT_EMITTER_SELECT_RESET  16'h0541
`define THIRD_DRIVER_CONTROL_RESET 16'h3000

`endif

// ### include/led_slot_pkg.sv
// Types shared by the emitter slot register bank and its slot decoder.
// No assumptions beyond a SystemVerilog compiler.
package led_slot_pkg;

  // Emitter field code of one time slot
  typedef enum logic [1:0] {
    EMITTER_NONE   = 2'h0,
    EMITTER_FIRST  = 2'h1,
    EMITTER_SECOND = 2'h2,
    EMITTER_THIRD  = 2'h3
  } emitter_code_e;

  typedef logic [15:0] reg_word_t;
  typedef logic [7:0]  reg_addr_t;

endpackage : led_slot_pkg

// ### rtl/slot_emitter_decode.sv
// Registered decode of one slot's emitter field into driver enables.
// Assumes the code input comes from logic on the same clock.
`timescale 1ns/1ps

module slot_emitter_decode (
  // Clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        resetn_i,
  // Emitter field of the slot
  input  wire led_slot_pkg::emitter_code_e code_i,
  // Driver pulse enables, one bit per driver, and diode float mode
  output logic [2:0]                       emitter_enable_o,
  output logic                             float_mode_o
);

  function automatic logic [2:0] decode_emitter(input led_slot_pkg::emitter_code_e code);
    logic [2:0] onehot;
    onehot = 3'h0;
    case (code)
      led_slot_pkg::EMITTER_FIRST:  onehot = 3'h1;
      led_slot_pkg::EMITTER_SECOND: onehot = 3'h2;
      led_slot_pkg::EMITTER_THIRD:  onehot = 3'h4;
      default:                      onehot = 3'h0;
    endcase
    return onehot;
  endfunction : decode_emitter

  wire logic [2:0] next_emitter_enable;
  wire logic       next_float_mode;

  assign next_emitter_enable = decode_emitter(code_i);
  assign next_float_mode     = (code_i == led_slot_pkg::EMITTER_NONE);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      emitter_enable_o <= 3'h0;
      float_mode_o     <= 1'b0;
    end else begin
      emitter_enable_o <= next_emitter_enable;
      float_mode_o     <= next_float_mode;
    end
  end

endmodule : slot_emitter_decode

// ### tb/led_slot_control_regs_props.sv
// Checker for the emitter slot register bank, bound to its top module.
// Assumes the register port and every output sit on clock_i.
`timescale 1ns/1ps
`include "led_slot_defs.svh"

module led_slot_control_regs_props (
  // Clock and reset
  input wire logic                    clock_i,
  input wire logic                    resetn_i,
  // Host register port
  input wire led_slot_pkg::reg_addr_t reg_addr_i,
  input wire logic                    reg_write_i,
  input wire led_slot_pkg::reg_word_t reg_wdata_i,
  input wire logic                    reg_read_i,
  input wire led_slot_pkg::reg_word_t reg_rdata_o,
  input wire logic                    reg_rvalid_o,
  // Slot and driver outputs
  input wire logic [3:0]              slot_a_diode_select_o,
  input wire logic [3:0]              slot_b_diode_select_o,
  input wire logic [2:0]              slot_a_emitter_enable_o,
  input wire logic [2:0]              slot_b_emitter_enable_o,
  input wire logic                    slot_a_float_mode_o,
  input wire logic                    slot_b_float_mode_o,
  input wire logic                    third_driver_strength_o,
  input wire logic [2:0]              third_driver_edge_rate_o,
  input wire logic [3:0]              third_driver_coarse_current_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire wr_sel = reg_write_i && reg_addr_i == `SLOT_EMITTER_SELECT_ADDR;
  wire wr_drv = reg_write_i && reg_addr_i == `THIRD_DRIVER_CONTROL_ADDR;
  wire rd_bad = reg_read_i && !(reg_addr_i inside {`SLOT_EMITTER_SELECT_ADDR,
                                                   `THIRD_DRIVER_CONTROL_ADDR});

  a_rvalid_follows_read: assert property (reg_read_i |=> reg_rvalid_o)
    else $error("read gave no valid pulse");
  a_rvalid_has_cause: assert property (reg_rvalid_o |-> $past(reg_read_i))
    else $error("valid pulse without read");
  a_rdata_holds: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (rd_bad |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_diode_follow: assert property (wr_sel |-> ##2
    {slot_b_diode_select_o, slot_a_diode_select_o} == $past(reg_wdata_i[11:4], 2))
    else $error("diode select not taken");
  a_third_follow: assert property (wr_drv |-> ##2 {third_driver_strength_o,
    third_driver_edge_rate_o, third_driver_coarse_current_o} ==
    {$past(reg_wdata_i[13], 2), $past(reg_wdata_i[6:0], 2)})
    else $error("third driver fields not taken");
  a_a_emitter_decode: assert property (wr_sel |-> ##3
    {slot_a_float_mode_o, slot_a_emitter_enable_o} == {$past(reg_wdata_i[1:0], 3) == 2'h0,
    3'((4'h1 << $past(reg_wdata_i[1:0], 3)) >> 1)})
    else $error("slot A emitter decode wrong");
  a_b_emitter_decode: assert property (wr_sel |-> ##3
    {slot_b_float_mode_o, slot_b_emitter_enable_o} == {$past(reg_wdata_i[3:2], 3) == 2'h0,
    3'((4'h1 << $past(reg_wdata_i[3:2], 3)) >> 1)})
    else $error("slot B emitter decode wrong");
  c_drv_write: cover property (wr_drv);
  c_bad_read: cover property (rd_bad);
  c_b_third: cover property (slot_b_emitter_enable_o == 3'h4);
endmodule : led_slot_control_regs_props

bind led_slot_control_regs led_slot_control_regs_props i_led_slot_control_regs_props (.*);

// ### tb/tb_led_slot_control_regs.sv
// Self-checking bench for the emitter slot register bank.
// Assumes the design and its bound checker are compiled ahead of it.
`timescale 1ns/1ps
`include "led_slot_defs.svh"

module tb_led_slot_control_regs;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  led_slot_pkg::reg_addr_t reg_addr_i = 8'h00;
  logic reg_write_i = 1'b0;
  led_slot_pkg::reg_word_t reg_wdata_i = 16'h0000;
  logic reg_read_i = 1'b0;
  led_slot_pkg::reg_word_t reg_rdata_o, s, t;
  logic reg_rvalid_o, slot_a_float_mode_o, slot_b_float_mode_o, third_driver_strength_o;
  logic [3:0] slot_a_diode_select_o, slot_b_diode_select_o, third_driver_coarse_current_o;
  logic [2:0] slot_a_emitter_enable_o, slot_b_emitter_enable_o, third_driver_edge_rate_o;
  int fails = 0;
  int samples_checked = 0;
  int seed = 43;

  led_slot_control_regs i_led_slot_control_regs (.*);

  initial forever #2.5 clock_i = ~clock_i;

  function automatic logic [2:0] en(input logic [1:0] c);
    return (c == 2'h0) ? 3'h0 : 3'(3'h1 << (c - 2'h1));
  endfunction : en

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i) reg_write_i <= 1'b0;
    @(posedge clock_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i) reg_read_i <= 1'b0;
    #1;
    chk(16'(reg_rvalid_o), 16'h0001);
    chk(reg_rdata_o, exp);
    @(posedge clock_i);
  endtask : rd

  // Reads both registers back, then compares every field output
  task automatic check_all();
    rd(`SLOT_EMITTER_SELECT_ADDR, s);
    rd(`THIRD_DRIVER_CONTROL_ADDR, t);
    #1;
    chk({slot_b_diode_select_o, slot_a_diode_select_o, slot_b_float_mode_o, slot_b_emitter_enable_o,
      slot_a_float_mode_o, slot_a_emitter_enable_o}, {s[11:4], s[3:2] == 2'h0, en(s[3:2]),
      s[1:0] == 2'h0, en(s[1:0])});
    chk({9'h000, third_driver_strength_o, third_driver_edge_rate_o, third_driver_coarse_current_o},
      {9'h000, t[13], t[6:0]});
    @(posedge clock_i);
  endtask : check_all

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial begin
    s = `SLOT_EMITTER_SELECT_RESET;
    t = `THIRD_DRIVER_CONTROL_RESET;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    check_all();
    for (int i = 0; i < 28; i++) begin
      s = 16'($random(seed)) & 16'h0FFF;
      t = (16'($random(seed)) & 16'h207F) | 16'h1000;
      if (i < 4) s[3:0] = {i[1:0], i[1:0]};
      if (i == 4) t = 16'h107F;
      wr(`SLOT_EMITTER_SELECT_ADDR, s);
      wr(`THIRD_DRIVER_CONTROL_ADDR, t);
      check_all();
    end
    wr(8'h30, 16'hFFFF);
    rd(8'h30, 16'h0000);
    check_all();
    // Reset in mid-run must bring back every default
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    s = `SLOT_EMITTER_SELECT_RESET;
    t = `THIRD_DRIVER_CONTROL_RESET;
    check_all();
    end_sim();
  end

  initial begin
    #50000;
    fails++;
    end_sim();
  end
endmodule : tb_led_slot_control_regs
